// ===== bench/sec_bus_model.sv
// behavioural graphics controller on the secondary bus: completions and error pulses
// assumes the bench raises go_in for one cycle per event, kind_in selecting the event
`timescale 1ns/10ps
module sec_bus_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // command from the bench
    input wire logic go_in,
    input wire logic [2:0] kind_in,
    input wire logic [31:0] data_in,
    // toward the bridge
    output logic cpl_valid_out,
    output logic cpl_abort_out,
    output logic cpl_write_out,
    output logic [31:0] cpl_data_out,
    output logic par_err_out,
    output logic other_err_out
);
    // ****************************************
    // kinds: 0 read, 1 write, 2 aborted read, 3 aborted write, 4 parity, 5 other
    // ****************************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cpl_valid_out <= 1'b0;
            cpl_abort_out <= 1'b0;
            cpl_write_out <= 1'b0;
            cpl_data_out <= 32'h00000000;
            par_err_out <= 1'b0;
            other_err_out <= 1'b0;
        end else begin
            cpl_valid_out <= go_in && !kind_in[2];
            cpl_abort_out <= go_in && kind_in[2:1] == 2'b01;
            cpl_write_out <= go_in && !kind_in[2] && kind_in[0];
            // data only meaningful on a good read, otherwise it keeps toggling
            cpl_data_out <= (go_in && kind_in == 3'd0) ? data_in : ~cpl_data_out;
            par_err_out <= go_in && kind_in == 3'd4;
            other_err_out <= go_in && kind_in == 3'd5;
        end
    end
endmodule

// ===== bench/testbench.sv
// self-checking bench of the bridge window block
// assumes the design files and the secondary bus model are compiled first
`timescale 1ns/10ps
module testbench;
    logic clk, rst, hsel, hwrite, req_valid, req_io, go;
    logic [1:0] htrans;
    logic [2:0] kind;
    logic [31:0] haddr, hwdata, req_addr, gdata, rdata;
    wire logic hready, hresp, rv, rs, rp, c_v, c_a, c_w, perr, oerr;
    wire logic cpl_v, wr_disc, b2b, msg, irq;
    wire logic [31:0] hrdata, c_d, cpl_d;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;

    bridge_prefetch_window_ctrl i_dut (
        .CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1),
        .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .HRDATA_OUT(hrdata),
        .REQ_VALID_IN(req_valid), .REQ_IO_IN(req_io), .REQ_ADDR_IN(req_addr),
        .ROUTE_VALID_OUT(rv), .ROUTE_SEC_OUT(rs), .ROUTE_PREFETCH_OUT(rp),
        .SEC_CPL_VALID_IN(c_v), .SEC_CPL_ABORT_IN(c_a), .SEC_CPL_WRITE_IN(c_w),
        .SEC_CPL_DATA_IN(c_d), .SEC_PARITY_ERR_IN(perr), .SEC_OTHER_ERR_IN(oerr),
        .CPU_CPL_VALID_OUT(cpl_v), .CPU_CPL_DATA_OUT(cpl_d),
        .CPU_WR_DISCARD_OUT(wr_disc), .SEC_FAST_B2B_OUT(b2b),
        .HUB_SERR_MSG_OUT(msg), .IRQ_OUT(irq));

    sec_bus_model i_sec (
        .clk_in(clk), .rst_in(rst), .go_in(go), .kind_in(kind), .data_in(gdata),
        .cpl_valid_out(c_v), .cpl_abort_out(c_a), .cpl_write_out(c_w),
        .cpl_data_out(c_d), .par_err_out(perr), .other_err_out(oerr));

    // ****************************************
    // shared tasks
    // ****************************************
    function automatic logic [31:0] ra(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction

    task automatic give_verdict;
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rdata = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(rdata, exp);
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic route(input logic io, input logic [31:0] a, input logic [2:0] e);
        @(posedge clk);
        req_valid <= 1'b1;
        req_io <= io;
        req_addr <= a;
        @(posedge clk);
        req_valid <= 1'b0;
        req_addr <= ~a;
        #1 check({29'h0, rv, rs, rp}, {29'h0, e});
    endtask

    task automatic sec(input logic [2:0] k, input logic [31:0] d);
        @(posedge clk);
        go <= 1'b1;
        kind <= k;
        gdata <= d;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        rd(ra(bridge_prefetch_window_pkg::PF_BASE_IDX), 32'h0000fff0);
        rd(ra(bridge_prefetch_window_pkg::PF_LIMIT_IDX), 32'h0);
        rd(ra(bridge_prefetch_window_pkg::BCTRL_IDX), 32'h0);
        route(1'b0, 32'h80000000, 3'b100);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::BCTRL_IDX), 32'h000000ff);
        rd(ra(bridge_prefetch_window_pkg::BCTRL_IDX), 32'h0000000d);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::BCTRL_IDX), 32'h0);
        ahb(1'b1, 32'h00000400, 32'hffffffff);
        rd(32'h00000400, 32'h0);
        check({31'h0, b2b}, 32'h0);
    endtask

    task automatic t_prefetch;
        ahb(1'b1, ra(bridge_prefetch_window_pkg::PF_BASE_IDX), 32'hffff123f);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::PF_LIMIT_IDX), 32'h0000124f);
        rd(ra(bridge_prefetch_window_pkg::PF_BASE_IDX), 32'h00001230);
        rd(ra(bridge_prefetch_window_pkg::PF_LIMIT_IDX), 32'h00001240);
        route(1'b0, 32'h12300000, 3'b111);
        route(1'b0, 32'h122fffff, 3'b100);
        route(1'b0, 32'h124fffff, 3'b111);
        route(1'b0, 32'h12500000, 3'b100);
    endtask

    task automatic t_vga;
        route(1'b0, 32'h000a0000, 3'b100);
        route(1'b1, 32'h000003c0, 3'b100);
        route(1'b0, 32'h000b0000, 3'b100);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::BCTRL_IDX), 32'h8);
        // monochrome select only once display routing is on
        ahb(1'b1, ra(bridge_prefetch_window_pkg::MISC_IDX), 32'h1);
        route(1'b0, 32'h000bffff, 3'b110);
        route(1'b1, 32'h000003df, 3'b110);
        route(1'b0, 32'h000b7fff, 3'b100);
        route(1'b1, 32'h000003bf, 3'b100);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::MISC_IDX), 32'h0);
        route(1'b0, 32'h000b0000, 3'b100);
        route(1'b0, 32'h000a0000, 3'b110);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::BCTRL_IDX), 32'h0);
    endtask

    task automatic t_io;
        ahb(1'b1, ra(bridge_prefetch_window_pkg::IOWIN_IDX), 32'h00002010);
        route(1'b1, 32'h00001100, 3'b110);
        route(1'b1, 32'h000023ff, 3'b110);
        route(1'b1, 32'h00003000, 3'b100);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::BCTRL_IDX), 32'h4);
        route(1'b1, 32'h00001100, 3'b100);
        route(1'b1, 32'h000023ff, 3'b100);
        route(1'b1, 32'h000010ff, 3'b110);
        route(1'b1, 32'h00002400, 3'b110);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::BCTRL_IDX), 32'h0);
    endtask

    task automatic t_cpl;
        sec(3'd0, 32'h12345678);
        check({30'h0, cpl_v, wr_disc}, 32'h2);
        check(cpl_d, 32'h12345678);
        sec(3'd1, 32'h0);
        check({30'h0, cpl_v, wr_disc}, 32'h2);
        sec(3'd2, 32'h0000abcd);
        check({30'h0, cpl_v, wr_disc}, 32'h2);
        check(cpl_d, 32'hffffffff);
        sec(3'd3, 32'h0);
        check({30'h0, cpl_v, wr_disc}, 32'h1);
    endtask

    task automatic t_err;
        ahb(1'b1, ra(bridge_prefetch_window_pkg::MASK_IDX), 32'h1);
        sec(3'd4, 32'h0);
        check({31'h0, msg}, 32'h0);
        @(posedge clk);
        #1 check({31'h0, irq}, 32'h1);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::MISC_IDX), 32'h2);
        sec(3'd4, 32'h0);
        check({31'h0, msg}, 32'h0);
        sec(3'd5, 32'h0);
        check({31'h0, msg}, 32'h1);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::BCTRL_IDX), 32'h1);
        sec(3'd4, 32'h0);
        check({31'h0, msg}, 32'h1);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::MISC_IDX), 32'h0);
        sec(3'd4, 32'h0);
        check({31'h0, msg}, 32'h0);
        rd(ra(bridge_prefetch_window_pkg::STAT_IDX), 32'h7);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::STAT_IDX), 32'h7);
        rd(ra(bridge_prefetch_window_pkg::STAT_IDX), 32'h0);
        check({31'h0, irq}, 32'h0);
        ahb(1'b1, ra(bridge_prefetch_window_pkg::MASK_IDX), 32'h0);
        sec(3'd4, 32'h0);
        @(posedge clk);
        #1 check({31'h0, irq}, 32'h0);
    endtask

    // ****************************************
    // clock, timeout, main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            give_verdict;
        end
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        req_valid = 1'b0;
        req_io = 1'b0;
        req_addr = 32'h0;
        go = 1'b0;
        kind = 3'd0;
        gdata = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_prefetch;
        t_vga;
        t_io;
        t_cpl;
        t_err;
        give_verdict;
    end
endmodule

// ===== verilog/bridge_prefetch_window_ctrl.sv
// window decode, bridge control and error reporting of the secondary graphics bridge
// assumes one clock, AHB-Lite register access and cycle inputs synchronous to CLK_IN
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps

// Operation
// - base <= address <= limit goes prefetchable
// - window bits 15:4 writable, 3:0 zero
// - base low twenty bits decode as zero
// - limit low twenty bits decode as ones
// - bit 7 zero, no fast back-to-back
// - bit 6 zero, no secondary reset
// - bit 5 zero, abort drops writes, reads ones
// - bit 3 enables legacy display routing
// - suppress clear forwards whole I/O window
// - suppress set sends alias I/O to hub
// - bit 1 zero, no error forwarding
// - parity response clear blocks parity messages
// - parity messages need both enables set
// - display disabled sends all legacy to hub
// - display enabled, VGA secondary, MDA hub
module bridge_prefetch_window_ctrl (
    // clock, reset, enable
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic CE_IN,
    // register port
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    output logic [31:0] HRDATA_OUT,
    // processor cycle to route
    input wire logic REQ_VALID_IN,
    input wire logic REQ_IO_IN,
    input wire logic [31:0] REQ_ADDR_IN,
    output logic ROUTE_VALID_OUT,
    output logic ROUTE_SEC_OUT,
    output logic ROUTE_PREFETCH_OUT,
    // secondary bus completion and errors
    input wire logic SEC_CPL_VALID_IN,
    input wire logic SEC_CPL_ABORT_IN,
    input wire logic SEC_CPL_WRITE_IN,
    input wire logic [31:0] SEC_CPL_DATA_IN,
    input wire logic SEC_PARITY_ERR_IN,
    input wire logic SEC_OTHER_ERR_IN,
    output logic CPU_CPL_VALID_OUT,
    output logic [31:0] CPU_CPL_DATA_OUT,
    output logic CPU_WR_DISCARD_OUT,
    output logic SEC_FAST_B2B_OUT,
    // hub side
    output logic HUB_SERR_MSG_OUT,
    output logic IRQ_OUT
);

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic pf_hit(input logic [31:0] a, input logic [15:0] b,
                                    input logic [15:0] l);
        logic [31:0] lo;
        logic [31:0] hi;
        lo = {b[15:4], 20'h00000};
        hi = {l[15:4], 20'hfffff};
        pf_hit = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic mda_hit(input logic io, input logic [31:0] a);
        if (io) begin
            mda_hit = (a[15:0] >= bridge_prefetch_window_pkg::MDA_IO_LO &&
                       a[15:0] <= bridge_prefetch_window_pkg::MDA_IO_HI) ||
                      a[15:0] == bridge_prefetch_window_pkg::MDA_IO_ALT;
        end else begin
            mda_hit = a >= bridge_prefetch_window_pkg::MDA_MEM_LO &&
                      a <= bridge_prefetch_window_pkg::MDA_MEM_HI;
        end
    endfunction

    function automatic logic vga_hit(input logic io, input logic [31:0] a);
        if (io) begin
            vga_hit = a[15:0] >= bridge_prefetch_window_pkg::VGA_IO_LO &&
                      a[15:0] <= bridge_prefetch_window_pkg::VGA_IO_HI;
        end else begin
            vga_hit = a >= bridge_prefetch_window_pkg::VGA_MEM_LO &&
                      a <= bridge_prefetch_window_pkg::VGA_MEM_HI &&
                      !mda_hit(1'b0, a);
        end
    endfunction

    function automatic logic io_alias(input logic [31:0] a);
        io_alias = a[9:8] != 2'b00;
    endfunction

    function automatic bridge_prefetch_window_pkg::route_t route_of(
        input logic io,
        input logic [31:0] a,
        input bridge_prefetch_window_pkg::state_t s);
        logic iow;
        logic legacy;
        route_of = '0;
        iow = a[15:12] >= s.iowin[7:4] && a[15:12] <= s.iowin[15:12];
        legacy = mda_hit(io, a) || vga_hit(io, a);
        if (legacy) begin
            // monochrome select never changes the outcome
            route_of.sec = vga_hit(io, a) &&
                           s.bctrl[bridge_prefetch_window_pkg::BC_VGA_EN];
        end else if (io) begin
            route_of.sec = iow;
            if (s.bctrl[bridge_prefetch_window_pkg::BC_ISA_SUP] && io_alias(a)) begin
                route_of.sec = 1'b0;
            end
        end else begin
            route_of.pf = pf_hit(a, s.pf_base, s.pf_limit);
            route_of.sec = route_of.pf;
        end
    endfunction

    function automatic logic [31:0] reg_read(input logic [7:0] idx,
                                             input bridge_prefetch_window_pkg::state_t s);
        reg_read = '0;
        unique case (idx)
            bridge_prefetch_window_pkg::PF_BASE_IDX: reg_read[15:0] = s.pf_base;
            bridge_prefetch_window_pkg::PF_LIMIT_IDX: reg_read[15:0] = s.pf_limit;
            bridge_prefetch_window_pkg::BCTRL_IDX: reg_read[7:0] = s.bctrl;
            bridge_prefetch_window_pkg::MISC_IDX: reg_read[1:0] = s.misc;
            bridge_prefetch_window_pkg::IOWIN_IDX: reg_read[15:0] = s.iowin;
            bridge_prefetch_window_pkg::STAT_IDX: reg_read[2:0] = s.stat;
            bridge_prefetch_window_pkg::MASK_IDX: reg_read[2:0] = s.mask;
            default: reg_read = '0;
        endcase
    endfunction

    // ****************************************
    // state
    // ****************************************
    bridge_prefetch_window_pkg::state_t st;
    bridge_prefetch_window_pkg::state_t next_st;

    logic take;
    logic [7:0] take_idx;
    logic [2:0] set_ev;
    logic [2:0] clr_ev;
    logic par_msg;

    assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign take_idx = (HADDR_IN[31:10] == 22'h000000) ? HADDR_IN[9:2] : 8'hff;

    always_comb begin
        next_st = st;
        clr_ev = 3'b000;
        // one-cycle strobes
        next_st.cpl_valid = 1'b0;
        next_st.wr_discard = 1'b0;
        next_st.route = '0;
        next_st.fb2b = 1'b0;

        // register write commits in its data phase
        if (st.wr_pend) begin
            next_st.wr_pend = 1'b0;
            unique case (st.wr_idx)
                bridge_prefetch_window_pkg::PF_BASE_IDX: begin
                    next_st.pf_base = HWDATA_IN[15:0] &
                                      bridge_prefetch_window_pkg::WIN_WR_MASK;
                end
                bridge_prefetch_window_pkg::PF_LIMIT_IDX: begin
                    next_st.pf_limit = HWDATA_IN[15:0] &
                                       bridge_prefetch_window_pkg::WIN_WR_MASK;
                end
                bridge_prefetch_window_pkg::BCTRL_IDX: begin
                    // bits 7, 6, 5, 4 and 1 stay zero
                    next_st.bctrl = HWDATA_IN[7:0] &
                                    bridge_prefetch_window_pkg::BC_WR_MASK;
                end
                bridge_prefetch_window_pkg::MISC_IDX: begin
                    next_st.misc = HWDATA_IN[1:0];
                end
                bridge_prefetch_window_pkg::IOWIN_IDX: begin
                    next_st.iowin = HWDATA_IN[15:0] & 16'hf0f0;
                end
                bridge_prefetch_window_pkg::STAT_IDX: begin
                    clr_ev = HWDATA_IN[2:0];
                end
                bridge_prefetch_window_pkg::MASK_IDX: begin
                    next_st.mask = HWDATA_IN[2:0];
                end
                default: begin
                    clr_ev = 3'b000;
                end
            endcase
        end

        // reads take one wait state so a preceding write is already visible
        if (st.rd_pend) begin
            next_st.rd_pend = 1'b0;
            next_st.hrdata = reg_read(st.rd_idx, st);
            next_st.hreadyout = 1'b1;
        end

        // address phase
        if (take) begin
            if (HWRITE_IN) begin
                next_st.wr_pend = 1'b1;
                next_st.wr_idx = take_idx;
            end else begin
                next_st.rd_pend = 1'b1;
                next_st.rd_idx = take_idx;
                next_st.hreadyout = 1'b0;
            end
        end

        // processor cycle routing
        if (REQ_VALID_IN) begin
            next_st.route = route_of(REQ_IO_IN, REQ_ADDR_IN, st);
            next_st.route.valid = 1'b1;
        end

        // completion from the secondary bus
        if (SEC_CPL_VALID_IN) begin
            next_st.cpl_valid = !(SEC_CPL_ABORT_IN && SEC_CPL_WRITE_IN);
            next_st.cpl_data = SEC_CPL_DATA_IN;
            if (SEC_CPL_ABORT_IN) begin
                next_st.cpl_data = 32'hffffffff;
                next_st.wr_discard = SEC_CPL_WRITE_IN;
            end
        end

        // error messaging toward the hub
        par_msg = SEC_PARITY_ERR_IN &&
                  st.bctrl[bridge_prefetch_window_pkg::BC_PAR_EN];
        next_st.serr_msg = (par_msg || SEC_OTHER_ERR_IN) &&
                           st.misc[bridge_prefetch_window_pkg::MISC_DEVMSG];

        // sticky status, a new event wins over a clear
        set_ev = '0;
        set_ev[bridge_prefetch_window_pkg::ST_PAR] = SEC_PARITY_ERR_IN;
        set_ev[bridge_prefetch_window_pkg::ST_ABORT] = SEC_CPL_VALID_IN && SEC_CPL_ABORT_IN;
        set_ev[bridge_prefetch_window_pkg::ST_MSG] = next_st.serr_msg;
        next_st.stat = (st.stat & ~clr_ev) | set_ev;
        next_st.irq = |(next_st.stat & next_st.mask);
        next_st.hresp = 1'b0;
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            st <= bridge_prefetch_window_pkg::ST_RST;
        end else if (CE_IN) begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign HREADYOUT_OUT = st.hreadyout;
    assign HRESP_OUT = st.hresp;
    assign HRDATA_OUT = st.hrdata;
    assign ROUTE_VALID_OUT = st.route.valid;
    assign ROUTE_SEC_OUT = st.route.sec;
    assign ROUTE_PREFETCH_OUT = st.route.pf;
    assign CPU_CPL_VALID_OUT = st.cpl_valid;
    assign CPU_CPL_DATA_OUT = st.cpl_data;
    assign CPU_WR_DISCARD_OUT = st.wr_discard;
    assign SEC_FAST_B2B_OUT = st.fb2b;
    assign HUB_SERR_MSG_OUT = st.serr_msg;
    assign IRQ_OUT = st.irq;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    logic mem_req;
    assign mem_req = CE_IN && REQ_VALID_IN && !REQ_IO_IN;

    // decode results kept as signals so they can be looked back at
    logic req_vga;
    logic req_vga_mem;
    assign req_vga = vga_hit(REQ_IO_IN, REQ_ADDR_IN);
    assign req_vga_mem = vga_hit(1'b0, REQ_ADDR_IN);

    property p_pf_window;
        mem_req && pf_hit(REQ_ADDR_IN, st.pf_base, st.pf_limit) &&
        !mda_hit(1'b0, REQ_ADDR_IN) && !vga_hit(1'b0, REQ_ADDR_IN)
        |=> ROUTE_VALID_OUT && ROUTE_SEC_OUT && ROUTE_PREFETCH_OUT;
    endproperty
    a_pf_window: assert property (p_pf_window) else $error("window hit not prefetched");

    property p_low_bits;
        st.pf_base[3:0] == 4'h0 && st.pf_limit[3:0] == 4'h0;
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("window low bits not zero");

    property p_base_edge;
        mem_req && REQ_ADDR_IN[19:0] == 20'h00000 && REQ_ADDR_IN[31:8] != 24'h000000 &&
        REQ_ADDR_IN[31:20] == st.pf_base[15:4] && st.pf_base <= st.pf_limit
        |=> ROUTE_PREFETCH_OUT;
    endproperty
    a_base_edge: assert property (p_base_edge) else $error("window bottom missed");

    property p_limit_edge;
        mem_req && REQ_ADDR_IN[19:0] == 20'hfffff &&
        REQ_ADDR_IN[31:20] == st.pf_limit[15:4] && st.pf_base <= st.pf_limit
        |=> ROUTE_PREFETCH_OUT;
    endproperty
    a_limit_edge: assert property (p_limit_edge) else $error("window top missed");

    property p_no_b2b;
        !SEC_FAST_B2B_OUT && st.bctrl[7] == 1'b0;
    endproperty
    a_no_b2b: assert property (p_no_b2b) else $error("back-to-back enabled");

    property p_ro_bits;
        st.bctrl[6:4] == 3'b000 && st.bctrl[1] == 1'b0;
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("read-only control bit set");

    property p_abort_read;
        CE_IN && SEC_CPL_VALID_IN && SEC_CPL_ABORT_IN && !SEC_CPL_WRITE_IN
        |=> CPU_CPL_VALID_OUT && CPU_CPL_DATA_OUT == 32'hffffffff && !CPU_WR_DISCARD_OUT;
    endproperty
    a_abort_read: assert property (p_abort_read) else $error("abort read not all ones");

    property p_isa_alias;
        CE_IN && REQ_VALID_IN && REQ_IO_IN && io_alias(REQ_ADDR_IN) &&
        st.bctrl[bridge_prefetch_window_pkg::BC_ISA_SUP]
        |=> ROUTE_VALID_OUT && !ROUTE_SEC_OUT;
    endproperty
    a_isa_alias: assert property (p_isa_alias) else $error("alias I/O forwarded");

    property p_io_window;
        CE_IN && REQ_VALID_IN && REQ_IO_IN &&
        !st.bctrl[bridge_prefetch_window_pkg::BC_ISA_SUP] &&
        !req_vga && !mda_hit(1'b1, REQ_ADDR_IN) &&
        REQ_ADDR_IN[15:12] >= st.iowin[7:4] && REQ_ADDR_IN[15:12] <= st.iowin[15:12]
        |=> ROUTE_VALID_OUT && ROUTE_SEC_OUT;
    endproperty
    a_io_window: assert property (p_io_window) else $error("window I/O not forwarded");

    property p_parity_off;
        CE_IN && !st.bctrl[bridge_prefetch_window_pkg::BC_PAR_EN] && !SEC_OTHER_ERR_IN
        |=> !HUB_SERR_MSG_OUT;
    endproperty
    a_parity_off: assert property (p_parity_off) else $error("parity message while off");

    property p_parity_on;
        CE_IN && SEC_PARITY_ERR_IN && st.bctrl[bridge_prefetch_window_pkg::BC_PAR_EN] &&
        st.misc[bridge_prefetch_window_pkg::MISC_DEVMSG]
        |=> HUB_SERR_MSG_OUT ##1 IRQ_OUT || !st.mask[bridge_prefetch_window_pkg::ST_MSG];
    endproperty
    a_parity_on: assert property (p_parity_on) else $error("parity message missing");

    property p_legacy_off;
        CE_IN && REQ_VALID_IN && (vga_hit(REQ_IO_IN, REQ_ADDR_IN) ||
        mda_hit(REQ_IO_IN, REQ_ADDR_IN)) && !st.bctrl[bridge_prefetch_window_pkg::BC_VGA_EN]
        |=> ROUTE_VALID_OUT && !ROUTE_SEC_OUT;
    endproperty
    a_legacy_off: assert property (p_legacy_off) else $error("legacy cycle forwarded");

    property p_vga_on;
        CE_IN && REQ_VALID_IN && st.bctrl[bridge_prefetch_window_pkg::BC_VGA_EN] &&
        (vga_hit(REQ_IO_IN, REQ_ADDR_IN) || mda_hit(REQ_IO_IN, REQ_ADDR_IN))
        |=> ROUTE_SEC_OUT == $past(req_vga);
    endproperty
    a_vga_on: assert property (p_vga_on) else $error("display routing wrong");

    property p_unmatched;
        mem_req && !pf_hit(REQ_ADDR_IN, st.pf_base, st.pf_limit)
        |=> !ROUTE_SEC_OUT || $past(req_vga_mem);
    endproperty
    a_unmatched: assert property (p_unmatched) else $error("stray memory forwarded");

endmodule

// ===== verilog/bridge_prefetch_window_pkg.sv
// register map, field layout, reset values and carrier types of the bridge window block
// assumes a single 40 MHz clock domain and an AHB-Lite register port
package bridge_prefetch_window_pkg;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [7:0] PF_BASE_IDX = 8'h24;
    localparam logic [7:0] PF_LIMIT_IDX = 8'h26;
    localparam logic [7:0] BCTRL_IDX = 8'h3e;
    localparam logic [7:0] MISC_IDX = 8'h41;
    localparam logic [7:0] IOWIN_IDX = 8'h42;
    localparam logic [7:0] STAT_IDX = 8'h43;
    localparam logic [7:0] MASK_IDX = 8'h44;

    // ****************************************
    // reset values and writable masks
    // ****************************************
    localparam logic [15:0] PF_BASE_RST = 16'hfff0;
    localparam logic [15:0] PF_LIMIT_RST = 16'h0000;
    localparam logic [7:0] BCTRL_RST = 8'h00;
    localparam logic [15:0] WIN_WR_MASK = 16'hfff0;
    localparam logic [7:0] BC_WR_MASK = 8'h0d;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BC_VGA_EN = 3;
    localparam int BC_ISA_SUP = 2;
    localparam int BC_PAR_EN = 0;
    localparam int MISC_MONO = 0;
    localparam int MISC_DEVMSG = 1;
    localparam int ST_PAR = 0;
    localparam int ST_ABORT = 1;
    localparam int ST_MSG = 2;

    // ****************************************
    // legacy display ranges
    // ****************************************
    localparam logic [31:0] VGA_MEM_LO = 32'h000a0000;
    localparam logic [31:0] VGA_MEM_HI = 32'h000bffff;
    localparam logic [31:0] MDA_MEM_LO = 32'h000b0000;
    localparam logic [31:0] MDA_MEM_HI = 32'h000b7fff;
    localparam logic [15:0] VGA_IO_LO = 16'h03c0;
    localparam logic [15:0] VGA_IO_HI = 16'h03df;
    localparam logic [15:0] MDA_IO_LO = 16'h03b0;
    localparam logic [15:0] MDA_IO_HI = 16'h03bb;
    localparam logic [15:0] MDA_IO_ALT = 16'h03bf;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        logic sec;
        logic pf;
    } route_t;

    typedef struct packed {
        logic [15:0] pf_base;
        logic [15:0] pf_limit;
        logic [7:0] bctrl;
        logic [1:0] misc;
        logic [15:0] iowin;
        logic [2:0] stat;
        logic [2:0] mask;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic rd_pend;
        logic [7:0] rd_idx;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        route_t route;
        logic fb2b;
        logic cpl_valid;
        logic [31:0] cpl_data;
        logic wr_discard;
        logic serr_msg;
        logic irq;
    } state_t;

    localparam state_t ST_RST = '{pf_base: PF_BASE_RST, pf_limit: PF_LIMIT_RST,
        bctrl: BCTRL_RST, hreadyout: 1'b1, default: '0};

endpackage
